//--- rtl/pll_ctrl_regs.svh
// Purpose: constants for the pll mode and fraction control block
// Assumes: included by its bare name
// Notes:   fraction has 11 fractional bits
`ifndef PLL_CTRL_REGS_SVH
`define PLL_CTRL_REGS_SVH
`define FRAC_BITS        11
`define MULT_W           19
`define ENCODED_FEEDBACK_DIVIDER_W           17
`define DEPTH_W          3
`define RATE_W           3
`define LOCK_COUNT       8
`define LOCK_CNT_W       4
`define SS_DIV_W         8
`define SS_STEPS         16
`define RST_MULT         19'h04000
`define RST_ENCODED_FEEDBACK_DIVIDER         17'h00000
`endif

//--- rtl/pll_ctrl_pkg.sv
// Purpose: types for the pll mode and fraction control block
// Assumes: pll_ctrl_regs.svh gives the widths
// Notes:   none
`include "pll_ctrl_regs.svh"
package pll_ctrl_pkg;
   typedef enum logic [1:0] {
      st_off    = 2'b00,
      st_acq    = 2'b01,
      st_locked = 2'b10
   } pll_state_t;

   typedef struct packed {
      logic                  pll_powerdown_bit;
      logic                  bypass;
      logic                  upper_limit_disable;
      logic                  band_select;
      logic                  feedback_half_bypass;
      logic                  fraction_bypass_select;
      logic                  spread_powerdown;
      logic [`ENCODED_FEEDBACK_DIVIDER_W-1:0]    encoded_feedback_divider;
      logic [`MULT_W-1:0]    fractional_multiplier;
      logic [`DEPTH_W-1:0]   modulation_depth;
      logic [`RATE_W-1:0]    modulation_rate;
   } pll_cfg_t;

   typedef struct packed {
      logic                  ref_off;
      logic                  osc_halt;
      logic                  divider_reset;
      logic                  feedback_div2;
      logic [`ENCODED_FEEDBACK_DIVIDER_W-1:0]    feedback_word;
      logic                  use_bypass;
   } pll_drive_t;
endpackage

//--- rtl/pll_mode_and_fraction_control.sv
// Purpose: control logic around a system pll: power-down, lock, fraction, spread
// Assumes: config bits are plain synchronous inputs; ref_tick marks a reference edge
// Notes:   analog loop is outside; phase_ok comes from the phase comparator
// Function
// RULE1: power-down bit set puts the pll into low-power state
// RULE2: power-down turns off reference, halts oscillator and detector, resets dividers
// RULE3: lock output stays low throughout power-down
// RULE4: after power-down clears, lock rises only once lock is regained
// RULE5: divider values written in power-down are held and used on exit
// RULE6: software sets mode bits per normal, fractional or spread spectrum mode
// RULE7: software sets bypass when powered down yet output path still used
// RULE8: no post-divide: output equals cco, doubled when halving stage active
// RULE9: post-divide enabled: output equals cco over two times p
// RULE10: software keeps cco 75 to 150 mhz, reference 4 khz to 25 mhz
// RULE11: fraction select 0 uses fractional multiplier; 1 uses encoded divider directly
// RULE12: fractional mode alternates m and m+1 to average the fraction
// RULE13: average cco is (2 minus half bypass) times multiplier over 2048 times ref
// RULE14: generator encodes plain divide values 1 to 255 into divider word
// RULE15: software keeps spread reference between 2 and 4 mhz, never 32 khz
// RULE16: zero modulation depth means no modulation, plain fractional pll
// RULE17: depth and rate are three bits; depth codes map factors 0 to 8
// RULE18: software moves clocks elsewhere before powering the pll down
`include "pll_ctrl_regs.svh"
module pll_mode_and_fraction_control #(
   parameter int unsigned LOCK_COUNT = `LOCK_COUNT
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire pll_ctrl_pkg::pll_cfg_t cfg,
   input  wire logic                   ref_tick,
   input  wire logic                   phase_ok,
   output logic                        lock,
   output pll_ctrl_pkg::pll_drive_t    drive,
   output logic [`SS_DIV_W-1:0]        feedback_m
);
   import pll_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // power state and lock detection
   pll_state_t             state;
   pll_state_t             next_state;
   logic [`LOCK_CNT_W-1:0] lock_cnt;
   logic                   pd;
   logic                   good_run;

   assign pd       = cfg.pll_powerdown_bit;
   assign good_run = (lock_cnt >= `LOCK_CNT_W'(LOCK_COUNT - 1));

   always_comb begin
      next_state = state;
      case (state)
         st_off:    next_state = pd ? st_off : st_acq;                  // see RULE1
         st_acq:    next_state = pd ? st_off :
                                 (ref_tick && phase_ok && good_run) ? st_locked : st_acq; // see RULE4
         st_locked: next_state = pd ? st_off :
                                 (ref_tick && !phase_ok) ? st_acq : st_locked;
         default:   next_state = st_off;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= st_off;
      end else begin
         state <= next_state;
      end
   end

   // one bad phase sample restarts the count, so lock never glitches high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_cnt <= '0;
      end else if (pd || (ref_tick && !phase_ok)) begin
         lock_cnt <= '0;
      end else if (ref_tick && !good_run) begin
         lock_cnt <= lock_cnt + `LOCK_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock <= 1'b0;
      end else begin
         lock <= (next_state == st_locked) && !pd;                       // see RULE3
      end
   end

   ////////////////////////////////////////////////////////////////////
   // held divider settings; latched at power-down exit
   logic [`MULT_W-1:0] mult_held;
   logic [`ENCODED_FEEDBACK_DIVIDER_W-1:0] encoded_feedback_divider_held;
   logic               exiting;

   assign exiting = (state == st_off) && !pd;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mult_held <= `RST_MULT;
         encoded_feedback_divider_held <= `RST_ENCODED_FEEDBACK_DIVIDER;
      end else if (exiting || state != st_off) begin
         mult_held <= cfg.fractional_multiplier;                        // see RULE5
         encoded_feedback_divider_held <= cfg.encoded_feedback_divider;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // spread modulation: triangular offset scaled by depth factor
   logic [4:0]  depth_k2;
   logic [`RATE_W+3:0] rate_cnt;
   logic [`RATE_W+3:0] rate_top;
   logic [3:0]  tri_pos;
   logic        tri_up;
   logic signed [`MULT_W+1:0] mod_offs;
   logic        run;

   assign run = (state != st_off);
   // factors doubled so 1.5 stays integral: 0,1,1.5,2,3,4,6,8
   assign depth_k2 = (cfg.modulation_depth == 3'h0) ? 5'h00 :
                     (cfg.modulation_depth == 3'h1) ? 5'h02 :
                     (cfg.modulation_depth == 3'h2) ? 5'h03 :
                     (cfg.modulation_depth == 3'h3) ? 5'h04 :
                     (cfg.modulation_depth == 3'h4) ? 5'h06 :
                     (cfg.modulation_depth == 3'h5) ? 5'h08 :
                     (cfg.modulation_depth == 3'h6) ? 5'h0C : 5'h10; // see RULE17
   assign rate_top = {1'b0, cfg.modulation_rate, 3'h7};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_cnt <= '0;
         tri_pos  <= '0;
         tri_up   <= 1'b1;
      end else if (!run) begin
         rate_cnt <= '0;
         tri_pos  <= '0;
         tri_up   <= 1'b1;
      end else if (ref_tick) begin
         if (rate_cnt >= rate_top) begin
            rate_cnt <= '0;
            tri_pos  <= tri_up ? tri_pos + 4'h1 : tri_pos - 4'h1;
            if (tri_up && tri_pos == 4'hE) begin
               tri_up <= 1'b0;
            end else if (!tri_up && tri_pos == 4'h1) begin
               tri_up <= 1'b1;
            end
         end else begin
            rate_cnt <= rate_cnt + (`RATE_W+4)'(1);
         end
      end
   end

   // centre spread: offset runs from -k*16 to +k*14 in fraction lsbs
   assign mod_offs = (depth_k2 == 5'h00) ? '0 :                          // see RULE16
                     (`MULT_W+2)'($signed({1'b0, tri_pos}) - 6'sd8) *
                     (`MULT_W+2)'($signed({1'b0, depth_k2}));

   ////////////////////////////////////////////////////////////////////
   // fractional accumulator: picks m or m+1 each feedback cycle
   logic [`MULT_W+1:0]    mult_eff;
   logic [`FRAC_BITS-1:0] frac_acc;
   logic [`FRAC_BITS:0]   frac_sum;
   logic [`SS_DIV_W-1:0]  m_int;
   logic                  carry;

   assign mult_eff = $unsigned($signed({2'b00, mult_held}) + mod_offs);
   assign m_int    = mult_eff[`FRAC_BITS+`SS_DIV_W-1:`FRAC_BITS];
   assign frac_sum = {1'b0, frac_acc} + {1'b0, mult_eff[`FRAC_BITS-1:0]};
   assign carry    = frac_sum[`FRAC_BITS];

   // average m equals multiplier / 2^11, so cco averages the fraction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frac_acc   <= '0;
         feedback_m <= '0;
      end else if (!run) begin
         frac_acc   <= '0;
         feedback_m <= '0;
      end else if (ref_tick) begin
         frac_acc   <= frac_sum[`FRAC_BITS-1:0];                        // see RULE13
         feedback_m <= carry ? m_int + `SS_DIV_W'(1) : m_int;           // see RULE12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // encoder: plain m in 1..255 to divider word (lfsr state after m-1 steps)
   function automatic logic [`ENCODED_FEEDBACK_DIVIDER_W-1:0] encode_m(input logic [`SS_DIV_W-1:0] m);
      logic [`ENCODED_FEEDBACK_DIVIDER_W-1:0] x;
      x = `ENCODED_FEEDBACK_DIVIDER_W'h00001;
      for (int i = 1; i < 256; i++) begin
         if (i < int'(m)) begin
            x = {x[`ENCODED_FEEDBACK_DIVIDER_W-2:0], x[16] ^ x[13]};
         end
      end
      return (m == '0) ? '0 : x;
   endfunction

   logic [`ENCODED_FEEDBACK_DIVIDER_W-1:0] enc_word;
   assign enc_word = encode_m(feedback_m);                              // see RULE14

   ////////////////////////////////////////////////////////////////////
   // drive outputs to the analog pll
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive <= '{ref_off: 1'b1, osc_halt: 1'b1, divider_reset: 1'b1,
                    feedback_div2: 1'b0, feedback_word: '0, use_bypass: 1'b0};
      end else begin
         drive.ref_off       <= pd;                                     // see RULE2
         drive.osc_halt      <= pd;
         drive.divider_reset <= pd;
         drive.feedback_div2 <= !cfg.feedback_half_bypass;              // see RULE8
         drive.feedback_word <= cfg.fraction_bypass_select ? encoded_feedback_divider_held : enc_word; // see RULE11
         drive.use_bypass    <= cfg.bypass;                             // see RULE7
      end
   end
endmodule

//--- bench/pll_ctrl_checker.sv
// Purpose: port assertions for the pll mode and fraction control block
// Assumes: one clock; rst async, active high
// Notes:   good_run mirrors the lock counter, so lock may not rise early
`include "pll_ctrl_regs.svh"
module pll_ctrl_checker
   import pll_ctrl_pkg::*;
#(
   parameter int unsigned LOCK_COUNT = `LOCK_COUNT
) (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire pll_ctrl_pkg::pll_cfg_t cfg,
   input wire logic                  ref_tick,
   input wire logic                  phase_ok,
   input wire logic                  lock,
   input wire pll_ctrl_pkg::pll_drive_t drive,
   input wire logic [`SS_DIV_W-1:0]  feedback_m
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] good_run;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////
   // saturates so a long locked run never wraps back below the count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) good_run <= 8'h00;
      else if (cfg.pll_powerdown_bit) good_run <= 8'h00;
      else if (ref_tick) good_run <= phase_ok ? good_run + {7'h00, good_run != 8'hFF} : 8'h00;
   end
   ////////////////////////////////////////////////////////////////////
   AST_PD_LOCK: assert property (cfg.pll_powerdown_bit |=> !lock) else $error("lock high in power-down");
   AST_PD_STOP: assert property (cfg.pll_powerdown_bit |=> drive.ref_off && drive.osc_halt && drive.divider_reset)
      else $error("power-down outputs not set");
   // the divider clears one cycle after the state has reached off
   AST_PD_FBM: assert property (cfg.pll_powerdown_bit [*2] |=> feedback_m == 8'h00) else $error("divider not reset");
   AST_RUN: assert property (!cfg.pll_powerdown_bit |=> !drive.divider_reset) else $error("dividers held in run");
   AST_LOCK_RISE: assert property ($rose(lock) |-> $past(ref_tick) && $past(phase_ok) && good_run >= LOCK_COUNT)
      else $error("lock rose early");
   AST_LOCK_DROP: assert property (lock && ref_tick && !phase_ok |=> !lock) else $error("lock kept on bad tick");
   AST_LOCK_HOLD: assert property (lock && !cfg.pll_powerdown_bit && !(ref_tick && !phase_ok) |=> lock)
      else $error("lock dropped");
   AST_HALF: assert property (1'b1 |=> drive.feedback_div2 == !$past(cfg.feedback_half_bypass))
      else $error("halving stage wrong");
   AST_BYPASS: assert property (1'b1 |=> drive.use_bypass == $past(cfg.bypass)) else $error("bypass wrong");
   AST_DIRECT: assert property ((!cfg.pll_powerdown_bit && cfg.fraction_bypass_select && $stable(cfg)) [*3]
      |-> drive.feedback_word == cfg.encoded_feedback_divider) else $error("direct word wrong");
   cover property ($rose(lock));
   cover property (lock && ref_tick && !phase_ok);
   cover property (cfg.pll_powerdown_bit && ref_tick && phase_ok);
endmodule
bind pll_mode_and_fraction_control pll_ctrl_checker #(.LOCK_COUNT(LOCK_COUNT)) chk (.clk(clk), .rst(rst), .cfg(cfg),
   .ref_tick(ref_tick), .phase_ok(phase_ok), .lock(lock), .drive(drive), .feedback_m(feedback_m));

//--- bench/tb_top.sv
// Purpose: directed bench for the pll mode and fraction control block
// Assumes: LOCK_COUNT shortened to LC; ticks spaced three cycles
// Notes:   odd tick spacing keeps the m / m+1 count exact either way
`include "pll_ctrl_regs.svh"
module tb_top;
   import pll_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LC = 3;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 ref_tick = 1'b0;
   logic                 phase_ok = 1'b0;
   logic                 lock;
   logic [`SS_DIV_W-1:0] feedback_m;
   pll_cfg_t             cfg;
   pll_drive_t           drive;
   int                   fails = 0;
   int                   check_count = 0;
   int                   cycles = 0;
   pll_mode_and_fraction_control #(.LOCK_COUNT(LC)) dut (.clk(clk), .rst(rst), .cfg(cfg), .ref_tick(ref_tick),
      .phase_ok(phase_ok), .lock(lock), .drive(drive), .feedback_m(feedback_m));
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (fails == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tick(input logic ok);
      @(posedge clk) ref_tick <= 1'b1;
      phase_ok <= ok;
      @(posedge clk) ref_tick <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_lock();
      repeat (LC - 1) tick(1'b1);
      check("lock early", lock, 0);
      tick(1'b1);
      check("lock", lock, 1);
      tick(1'b0);
      check("lock drop", lock, 0);
      repeat (LC) tick(1'b1);
   endtask
   task automatic t_pd();
      @(posedge clk) cfg.pll_powerdown_bit <= 1'b1;
      cfg.bypass <= 1'b1;
      repeat (3) @(negedge clk);
      check("pd lock", lock, 0);
      check("pd stop", {drive.ref_off, drive.osc_halt, drive.divider_reset}, 3'h7);
      check("pd m", feedback_m, 0);
      @(posedge clk) cfg.encoded_feedback_divider <= 17'h1ABCD;
      repeat (LC + 1) tick(1'b1);
      check("pd relock", lock, 0);
      check("pd word", drive.feedback_word, 17'h00000);
      @(posedge clk) cfg.pll_powerdown_bit <= 1'b0;
      repeat (4) @(negedge clk);
      check("held word", drive.feedback_word, 17'h1ABCD);
      check("run", drive.divider_reset, 0);
   endtask
   task automatic t_frac();
      int n6;
      int bad;
      @(posedge clk) cfg.fraction_bypass_select <= 1'b0;
      cfg.upper_limit_disable <= 1'b1;
      cfg.band_select <= 1'b0;
      cfg.spread_powerdown <= 1'b0;
      cfg.fractional_multiplier <= {8'h05, 11'h400};
      for (int d = 0; d < 8; d++) begin
         @(posedge clk) cfg.modulation_depth <= d[2:0];
         n6 = 0;
         bad = 0;
         repeat (32) begin
            tick(1'b1);
            n6 += (feedback_m === 8'h06);
            bad += !(feedback_m === 8'h05 || feedback_m === 8'h06);
         end
         check("m range", bad, 0);
         if (d == 0) check("m+1 share", n6, 16);
      end
   endtask
   task automatic t_enc();
      for (int m = 0; m < 2; m++) begin
         @(posedge clk) cfg.fractional_multiplier <= {m[7:0], 11'h000};
         cfg.modulation_depth <= 3'h0;
         repeat (4) tick(1'b1);
         check("plain m", feedback_m, m);
         check("enc word", drive.feedback_word, m);
      end
   endtask
   task automatic t_bits();
      for (int i = 0; i < 2; i++) begin
         @(posedge clk) cfg.feedback_half_bypass <= i[0];
         cfg.bypass <= i[0];
         repeat (2) @(negedge clk);
         check("half", drive.feedback_div2, !i[0]);
         check("bypass", drive.use_bypass, i[0]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      cfg = '0;
      cfg.band_select = 1'b1;
      cfg.fraction_bypass_select = 1'b1;
      cfg.spread_powerdown = 1'b1;
      cfg.fractional_multiplier = `RST_MULT;
      repeat (7) @(posedge clk);
      @(negedge clk);
      check("rst out", {lock, drive.divider_reset, feedback_m}, {1'b0, 1'b1, 8'h00});
      @(posedge clk) rst <= 1'b0;
      t_lock();
      t_pd();
      t_bits();
      t_frac();
      t_enc();
      close_out();
   end
endmodule
